// ===== core/dpm_pin_cell.sv
// Ownership selector for one bidirectional pin.
// Assumes all inputs are on the system clock; the caller registers the outputs.
`timescale 1ns/100ps
module dpm_pin_cell (
    input  wire logic bus_own_i,
    input  wire logic bus_out_i,
    input  wire logic bus_oe_i,
    input  wire logic ctl_in_i,
    input  wire logic per_en_i,
    input  wire logic per_out_i,
    input  wire logic dir_i,
    input  wire logic lat_i,
    output logic      out_o,
    output logic      oe_o
);
    // Fixed priority, stored direction untouched
    always_comb begin
        if (bus_own_i) begin
            out_o = bus_out_i;
            oe_o  = bus_oe_i;
        end else if (ctl_in_i) begin
            out_o = 1'b0;
            oe_o  = 1'b0;
        end else if (per_en_i) begin
            out_o = per_out_i;
            oe_o  = 1'b1;
        end else begin
            out_o = lat_i;
            oe_o  = ~dir_i;
        end
    end
endmodule

// ===== core/dpm_pkg.sv
// Constants shared by the dual port pin logic: register offsets, control bits, reset values.
// Assumes a 32-bit APB master with byte addresses on an 8-bit paddr.
// Behaviour
// - Direction one makes second-port pin high impedance
// - Direction zero drives second-port latch onto pin
// - Latch register reads return latch, not pins
// - Second-port pins 6..0 inputs, analog read zero
// - Slave mode: low read plus select reads
// - Slave mode: low write plus select writes
// - Slave mode: first-port bit 2 low selects
// - Schmitt in port/PWM, TTL in bus/slave
// - Bus mode: first-port pin n carries bit n+8
// - First-port pins carry the eight PWM outputs
// - Remap moves four PWM outputs to port H
// - Capture 2 on port C1 or first-port 7 (external modes: output on neither, input from first-port 7)
// - Second-port bit 7 general or slave select
// - Second-port bits 1,2 drive comparator results
// - Second-port bit 5 routes comparator reference out
// - Slave enable turns first-port 2..0 into inputs
// - First-port general use only with bus disabled
// - External modes: first port is bus high byte
package dpm_pkg;
    localparam logic [7:0]  OFF_PE_DIR     = 8'h00;
    localparam logic [7:0]  OFF_PE_PIN     = 8'h04;
    localparam logic [7:0]  OFF_PE_LAT     = 8'h08;
    localparam logic [7:0]  OFF_PF_DIR     = 8'h0C;
    localparam logic [7:0]  OFF_PF_PIN     = 8'h10;
    localparam logic [7:0]  OFF_PF_LAT     = 8'h14;
    localparam logic [7:0]  OFF_CTRL       = 8'h18;
    localparam logic [7:0]  OFF_ANA        = 8'h1C;
    localparam logic [7:0]  OFF_STATUS     = 8'h20;
    localparam int          CTL_EXT_BUS_DISABLE      = 0;
    localparam int          CTL_PSP_EN     = 1;
    localparam int          CTL_PWM_REMAP  = 2;
    localparam int          CTL_CAP2_REMAP = 3;
    localparam int          CTL_CMP_OE     = 4;
    localparam int          CTL_COMPARATOR_REF_VOLTAGE_OE   = 5;
    localparam int          CTL_SS_EN      = 6;
    localparam int          CTL_SS_TTL     = 7;
    localparam int          ST_MCU_MODE    = 0;
    localparam int          ST_BUS_OWN     = 1;
    localparam int          ST_PSP_ACT     = 2;
    localparam logic [7:0]  DIR_RST        = 8'hFF;
    localparam logic [7:0]  LAT_RST        = 8'h00;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [6:0]  ANA_RST        = 7'h7F;
    localparam int          PSP_BITS       = 3;
    localparam logic [1:0]  STRAP_WAIT     = 2'h2;
endpackage

// ===== core/dpm_port_mux.sv
// Top of the dual port pin logic: APB registers, pin ownership and read paths.
// Assumes peripherals and the bus controller sit on mclk_i; pins are asynchronous.
`timescale 1ns/100ps
module dpm_port_mux
    import dpm_pkg::*;
#(
    parameter int PW = 8
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          proc_mode_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [7:0]    paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic [PW-1:0] pe_in_i,
    output logic      [PW-1:0] pe_out_o,
    output logic      [PW-1:0] pe_oe_o,
    output logic      [PW-1:0] pe_ttl_sel_o,
    input  wire logic [PW-1:0] pf_in_i,
    output logic      [PW-1:0] pf_out_o,
    output logic      [PW-1:0] pf_oe_o,
    output logic               pf_ss_ttl_o,
    input  wire logic [PW-1:0] ebus_ad_out_i,
    input  wire logic          ebus_ad_oe_i,
    output logic      [PW-1:0] ebus_ad_in_o,
    output logic               psp_read_o,
    output logic               psp_write_o,
    output logic               psp_select_o,
    input  wire logic [PW-1:0] pwm_out_i,
    input  wire logic [PW-1:0] pwm_en_i,
    output logic      [3:0]    ph_pwm_out_o,
    output logic      [3:0]    ph_pwm_oe_o,
    input  wire logic          pc1_in_i,
    output logic               pc1_cap2_out_o,
    output logic               pc1_cap2_oe_o,
    output logic               capture2_in_o,
    input  wire logic          comparator1_result_i,
    input  wire logic          comparator2_result_i,
    output logic               comparator_ref_voltage_route_o,
    output logic               ss_in_o
);
    logic          rst_n_s;
    logic          mode_s;
    logic [PW-1:0] pe_s;
    logic [PW-1:0] pf_s;
    logic          pc1_s;

    dpm_sync #(.W(1)) u_rst_sync (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     (1'b1),
        .q_o     (rst_n_s)
    );

    dpm_sync #(.W(2*PW+2)) u_pin_sync (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_s),
        .d_i     ({proc_mode_i, pc1_in_i, pf_in_i, pe_in_i}),
        .q_o     ({mode_s, pc1_s, pf_s, pe_s})
    );

    // Strap capture: waits until the pin synchroniser holds the strap, then latches once
    logic       strap_done_r;
    logic       strap_done_nxt;
    logic [1:0] strap_cnt_r;
    logic [1:0] strap_cnt_nxt;
    logic       strap_take;
    logic       mcu_mode_r;
    logic       mcu_mode_nxt;

    always_comb begin
        strap_take     = (strap_cnt_r == STRAP_WAIT) & ~strap_done_r;
        strap_cnt_nxt  = (strap_cnt_r == STRAP_WAIT) ? strap_cnt_r : strap_cnt_r + 2'h1;
        strap_done_nxt = strap_done_r | strap_take;
        mcu_mode_nxt   = strap_take ? mode_s : mcu_mode_r;
    end

    always_ff @(posedge mclk_i or negedge rst_n_s) begin
        if (!rst_n_s) begin
            strap_done_r <= 1'b0;
            strap_cnt_r  <= 2'h0;
            mcu_mode_r   <= 1'b1;
        end else begin
            strap_done_r <= strap_done_nxt;
            strap_cnt_r  <= strap_cnt_nxt;
            mcu_mode_r   <= mcu_mode_nxt;
        end
    end

    // Register file
    logic [PW-1:0] pe_dir_r;
    logic [PW-1:0] pe_dir_nxt;
    logic [PW-1:0] pe_lat_r;
    logic [PW-1:0] pe_lat_nxt;
    logic [PW-1:0] pf_dir_r;
    logic [PW-1:0] pf_dir_nxt;
    logic [PW-1:0] pf_lat_r;
    logic [PW-1:0] pf_lat_nxt;
    logic [7:0]    ctrl_r;
    logic [7:0]    ctrl_nxt;
    logic [6:0]    pf_ana_r;
    logic [6:0]    pf_ana_nxt;
    logic          bus_own;
    logic          psp_active;
    logic          apb_wr;
    logic [7:0]    wbyte;

    assign bus_own    = ~mcu_mode_r & ~ctrl_r[CTL_EXT_BUS_DISABLE];
    assign psp_active = mcu_mode_r & ctrl_r[CTL_PSP_EN];
    assign apb_wr     = psel_i & penable_i & pready_o & pwrite_i;
    assign wbyte      = pwdata_i[7:0];

    always_comb begin
        pe_dir_nxt = pe_dir_r;
        pe_lat_nxt = pe_lat_r;
        pf_dir_nxt = pf_dir_r;
        pf_lat_nxt = pf_lat_r;
        ctrl_nxt   = ctrl_r;
        pf_ana_nxt = pf_ana_r;
        if (apb_wr) begin
            case (paddr_i)
                OFF_PE_DIR: pe_dir_nxt = wbyte;
                OFF_PE_PIN: pe_lat_nxt = wbyte;
                OFF_PE_LAT: pe_lat_nxt = wbyte;
                OFF_PF_DIR: pf_dir_nxt = wbyte;
                OFF_PF_PIN: pf_lat_nxt = wbyte;
                OFF_PF_LAT: pf_lat_nxt = wbyte;
                OFF_CTRL:   ctrl_nxt   = wbyte;
                OFF_ANA:    pf_ana_nxt = wbyte[6:0];
                default:    ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pe_dir_r <= DIR_RST;
            pe_lat_r <= LAT_RST;
            pf_dir_r <= DIR_RST;
            pf_lat_r <= LAT_RST;
            ctrl_r   <= CTRL_RST;
            pf_ana_r <= ANA_RST;
        end else begin
            pe_dir_r <= pe_dir_nxt;
            pe_lat_r <= pe_lat_nxt;
            pf_dir_r <= pf_dir_nxt;
            pf_lat_r <= pf_lat_nxt;
            ctrl_r   <= ctrl_nxt;
            pf_ana_r <= pf_ana_nxt;
        end
    end

    // APB answer: one wait state, then pready with data
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic [7:0]  rbyte;
    logic        hit;

    always_comb begin
        rbyte = 8'h00;
        hit   = 1'b1;
        case (paddr_i)
            OFF_PE_DIR: rbyte = pe_dir_r;
            OFF_PE_PIN: rbyte = pe_s;
            OFF_PE_LAT: rbyte = pe_lat_r;
            OFF_PF_DIR: rbyte = pf_dir_r;
            OFF_PF_PIN: rbyte = {pf_s[7], pf_s[6:0] & ~pf_ana_r};
            OFF_PF_LAT: rbyte = pf_lat_r;
            OFF_CTRL:   rbyte = ctrl_r;
            OFF_ANA:    rbyte = {1'b0, pf_ana_r};
            OFF_STATUS: rbyte = {5'h00, psp_active, bus_own, mcu_mode_r};
            default:    hit   = 1'b0;
        endcase
        pready_nxt  = psel_i & penable_i & ~pready_o;
        prdata_nxt  = prdata_o;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            prdata_nxt  = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rbyte};
            pslverr_nxt = ~hit;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_s) begin
        if (!rst_n_s) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= prdata_nxt;
            pready_o  <= pready_nxt;
            pslverr_o <= pslverr_nxt;
        end
    end

    // Peripheral overrides per pin
    logic [PW-1:0] pe_per_en;
    logic [PW-1:0] pe_ctl_in;
    logic [PW-1:0] pf_per_en;
    logic [PW-1:0] pf_per_out;
    logic [PW-1:0] pf_ctl_in;
    logic          cap2_on_pe;
    logic          cap2_on_pc1;

    always_comb begin
        cap2_on_pe  = mcu_mode_r & ~ctrl_r[CTL_CAP2_REMAP];
        cap2_on_pc1 = mcu_mode_r & ctrl_r[CTL_CAP2_REMAP];
        pe_per_en   = pwm_en_i;
        if (ctrl_r[CTL_PWM_REMAP]) begin
            pe_per_en[6:3] = 4'h0;
        end
        pe_per_en[7] = pwm_en_i[7] & cap2_on_pe;
        pe_ctl_in    = '0;
        pe_ctl_in[PSP_BITS-1:0] = {PSP_BITS{psp_active}};
        pf_per_en    = '0;
        pf_per_out   = '0;
        pf_per_en[1] = ctrl_r[CTL_CMP_OE];
        pf_per_out[1] = comparator2_result_i;
        pf_per_en[2] = ctrl_r[CTL_CMP_OE];
        pf_per_out[2] = comparator1_result_i;
        pf_ctl_in    = '0;
        pf_ctl_in[5] = ctrl_r[CTL_COMPARATOR_REF_VOLTAGE_OE];
        pf_ctl_in[7] = ctrl_r[CTL_SS_EN];
    end

    logic [PW-1:0] pe_out_nxt;
    logic [PW-1:0] pe_oe_nxt;
    logic [PW-1:0] pf_out_nxt;
    logic [PW-1:0] pf_oe_nxt;

    for (genvar n = 0; n < PW; n++) begin : g_pin
        dpm_pin_cell u_pe_cell (
            .bus_own_i (bus_own),
            .bus_out_i (ebus_ad_out_i[n]),
            .bus_oe_i  (ebus_ad_oe_i),
            .ctl_in_i  (pe_ctl_in[n]),
            .per_en_i  (pe_per_en[n]),
            .per_out_i (pwm_out_i[n]),
            .dir_i     (pe_dir_r[n]),
            .lat_i     (pe_lat_r[n]),
            .out_o     (pe_out_nxt[n]),
            .oe_o      (pe_oe_nxt[n])
        );
        dpm_pin_cell u_pf_cell (
            .bus_own_i (1'b0),
            .bus_out_i (1'b0),
            .bus_oe_i  (1'b0),
            .ctl_in_i  (pf_ctl_in[n]),
            .per_en_i  (pf_per_en[n]),
            .per_out_i (pf_per_out[n]),
            .dir_i     (pf_dir_r[n]),
            .lat_i     (pf_lat_r[n]),
            .out_o     (pf_out_nxt[n]),
            .oe_o      (pf_oe_nxt[n])
        );
    end

    // Registered pin and side outputs
    logic [PW-1:0] ttl_nxt;
    logic          psp_rd_nxt;
    logic          psp_wr_nxt;
    logic          psp_cs_nxt;

    always_comb begin
        ttl_nxt = bus_own ? {PW{1'b1}} : {{(PW-PSP_BITS){1'b0}}, pe_ctl_in[PSP_BITS-1:0]};
        psp_cs_nxt = psp_active & ~pe_s[2];
        psp_rd_nxt = psp_cs_nxt & ~pe_s[0];
        psp_wr_nxt = psp_cs_nxt & ~pe_s[1];
    end

    always_ff @(posedge mclk_i or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pe_out_o       <= '0;
            pe_oe_o        <= '0;
            pf_out_o       <= '0;
            pf_oe_o        <= '0;
            pe_ttl_sel_o   <= '0;
            pf_ss_ttl_o    <= 1'b0;
            ebus_ad_in_o   <= '0;
            psp_read_o     <= 1'b0;
            psp_write_o    <= 1'b0;
            psp_select_o   <= 1'b0;
            ph_pwm_out_o   <= 4'h0;
            ph_pwm_oe_o    <= 4'h0;
            pc1_cap2_out_o <= 1'b0;
            pc1_cap2_oe_o  <= 1'b0;
            capture2_in_o  <= 1'b0;
            comparator_ref_voltage_route_o  <= 1'b0;
            ss_in_o        <= 1'b0;
        end else begin
            pe_out_o       <= pe_out_nxt;
            pe_oe_o        <= pe_oe_nxt;
            pf_out_o       <= pf_out_nxt;
            pf_oe_o        <= pf_oe_nxt;
            pe_ttl_sel_o   <= ttl_nxt;
            pf_ss_ttl_o    <= ctrl_r[CTL_SS_TTL];
            ebus_ad_in_o   <= pe_s;
            psp_read_o     <= psp_rd_nxt;
            psp_write_o    <= psp_wr_nxt;
            psp_select_o   <= psp_cs_nxt;
            ph_pwm_out_o   <= pwm_out_i[6:3];
            ph_pwm_oe_o    <= ctrl_r[CTL_PWM_REMAP] ? pwm_en_i[6:3] : 4'h0;
            pc1_cap2_out_o <= pwm_out_i[7];
            pc1_cap2_oe_o  <= cap2_on_pc1 & pwm_en_i[7];
            capture2_in_o  <= cap2_on_pc1 ? pc1_s : pe_s[7];
            comparator_ref_voltage_route_o  <= ctrl_r[CTL_COMPARATOR_REF_VOLTAGE_OE];
            ss_in_o        <= pf_s[7];
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_s);

    sequence s_rd_req(logic [7:0] off);
        psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == off;
    endsequence

    sequence s_remap_on;
        ctrl_r[CTL_PWM_REMAP] && pwm_en_i[6];
    endsequence

    a_pf_dir_hiz: assert property (pf_dir_r[0] |=> !pf_oe_o[0])
        else $error("second-port input pin still driven");
    a_pf_out_drive: assert property (!pf_dir_r[0] |=>
        pf_oe_o[0] && pf_out_o[0] == $past(pf_lat_r[0]))
        else $error("second-port output pin not driving latch");
    a_latch_read: assert property (s_rd_req(OFF_PE_LAT) |=>
        pready_o && prdata_o[7:0] == $past(pe_lat_r))
        else $error("latch read does not return latch");
    a_analog_zero: assert property (s_rd_req(OFF_PF_PIN) |=>
        (prdata_o[6:0] & $past(pf_ana_r)) == 7'h00)
        else $error("analog pin read not zero");
    a_psp_read: assert property (psp_active && !pe_s[2] && !pe_s[0] |=> psp_read_o && psp_select_o)
        else $error("slave read strobe missed");
    a_psp_write: assert property (psp_active && !pe_s[2] && !pe_s[1] |=> psp_write_o && psp_select_o)
        else $error("slave write strobe missed");
    a_psp_desel: assert property (psp_active && pe_s[2] |=> !psp_select_o && !psp_write_o && !psp_read_o)
        else $error("slave strobe without select");
    a_bus_own: assert property (bus_own |=>
        pe_oe_o == {PW{$past(ebus_ad_oe_i)}} && pe_out_o == $past(ebus_ad_out_i))
        else $error("bus does not own first port");
    a_ttl_sel: assert property (bus_own |=> pe_ttl_sel_o == 8'hFF)
        else $error("bus mode buffer not TTL");
    a_psp_ctl_in: assert property (psp_active && !bus_own |=> pe_oe_o[2:0] == 3'h0)
        else $error("slave control pin driven");
    a_remap_ph: assert property (s_remap_on ##0 !bus_own |=>
        ph_pwm_oe_o[3] && pe_oe_o[6] == !$past(pe_dir_r[6]))
        else $error("remapped pwm still on first port");
endmodule

// ===== core/dpm_sync.sv
// Two-stage synchroniser for a group of level signals.
// Assumes the inputs come from pins or an asynchronous source.
`timescale 1ns/100ps
module dpm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // First stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// ===== verification/dpm_pin_model.sv
// Far-side pin model for one 8-bit port: resolves each pad level.
// Assumes the bench supplies what the outside world drives on undriven pads.
`timescale 1ns/100ps
module dpm_pin_model (
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pin_o
);
    // Driven pads show the port value, released pads the outside value
    assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

// ===== verification/dual_port_pin_mux_logic_tb.sv
// Self-checking bench for the dual port pin logic.
// Assumes pads are resolved by dpm_pin_model; APB master acts on rising edges.
`timescale 1ns/100ps
module dual_port_pin_mux_logic_tb;
    import dpm_pkg::*;
    logic        mclk_i = 0, rst_n_i = 0, proc_mode_i = 1;
    logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0]  paddr_i = 0, pe_ext = 8'h00, pf_ext = 8'hFF;
    logic [31:0] pwdata_i = 0, prdata_o;
    logic        pready_o, pslverr_o, pf_ss_ttl_o, ebus_ad_oe_i = 0;
    logic [7:0]  pe_in_i, pe_out_o, pe_oe_o, pe_ttl_sel_o, pf_in_i, pf_out_o, pf_oe_o;
    logic [7:0]  ebus_ad_out_i = 0, ebus_ad_in_o, pwm_out_i = 0, pwm_en_i = 0;
    logic        psp_read_o, psp_write_o, psp_select_o, pc1_in_i = 0;
    logic [3:0]  ph_pwm_out_o, ph_pwm_oe_o;
    logic        pc1_cap2_out_o, pc1_cap2_oe_o, capture2_in_o, comparator_ref_voltage_route_o, ss_in_o;
    logic        comparator1_result_i = 0, comparator2_result_i = 0;
    logic [7:0]  d, l, x, c, m;
    logic [33:0] n;
    logic [33:0] q[$];
    int          err_total = 0, total_checks = 0, i;

    dpm_pin_model pe_pads (.out_i(pe_out_o), .oe_i(pe_oe_o), .ext_i(pe_ext), .pin_o(pe_in_i));
    dpm_pin_model pf_pads (.out_i(pf_out_o), .oe_i(pf_oe_o), .ext_i(pf_ext), .pin_o(pf_in_i));

    dpm_port_mux #(.PW(8)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .proc_mode_i(proc_mode_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pe_in_i(pe_in_i), .pe_out_o(pe_out_o), .pe_oe_o(pe_oe_o), .pe_ttl_sel_o(pe_ttl_sel_o),
        .pf_in_i(pf_in_i), .pf_out_o(pf_out_o), .pf_oe_o(pf_oe_o), .pf_ss_ttl_o(pf_ss_ttl_o),
        .ebus_ad_out_i(ebus_ad_out_i), .ebus_ad_oe_i(ebus_ad_oe_i), .ebus_ad_in_o(ebus_ad_in_o),
        .psp_read_o(psp_read_o), .psp_write_o(psp_write_o), .psp_select_o(psp_select_o),
        .pwm_out_i(pwm_out_i), .pwm_en_i(pwm_en_i), .ph_pwm_out_o(ph_pwm_out_o),
        .ph_pwm_oe_o(ph_pwm_oe_o), .pc1_in_i(pc1_in_i), .pc1_cap2_out_o(pc1_cap2_out_o),
        .pc1_cap2_oe_o(pc1_cap2_oe_o), .capture2_in_o(capture2_in_o),
        .comparator1_result_i(comparator1_result_i),
        .comparator2_result_i(comparator2_result_i), .comparator_ref_voltage_route_o(comparator_ref_voltage_route_o),
        .ss_in_o(ss_in_o));

    initial begin
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer; the expected answer is noted before the request
    task automatic apb(logic wr, logic [7:0] a, logic [7:0] dat, logic [7:0] exp, logic err);
        q.push_back({~wr, err, 24'h0, exp});
        @(posedge mclk_i);
        psel_i    <= 1;
        penable_i <= 0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= {24'h0, dat};
        @(posedge mclk_i);
        penable_i <= 1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        psel_i    <= 0;
        penable_i <= 0;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] dat);
        apb(1, a, dat, 8'h00, 0);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] exp);
        apb(0, a, 8'h00, exp, 0);
    endtask

    task automatic sett(int k);
        repeat (k) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic do_reset(logic mode);
        @(posedge mclk_i);
        rst_n_i     <= 0;
        proc_mode_i <= mode;
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1;
        repeat (6) @(posedge mclk_i);
    endtask

    // Answer watcher: takes the oldest note whenever pready_o shows
    always @(negedge mclk_i) begin
        if (pready_o === 1'b1) begin
            if (q.size() == 0) begin
                check("apb_note", 8'h00, 8'h01);
            end else begin
                n = q.pop_front();
                if (n[33]) check("prdata", prdata_o[7:0], n[7:0]);
                if (n[33]) check("prdata_hi", {7'h0, |prdata_o[31:8]}, 8'h00);
                check("pslverr", {7'h0, pslverr_o}, {7'h0, n[32]});
            end
        end
    end

    initial begin
        #(50 * 20000);
        err_total++;
        end_sim();
    end

    initial begin
        void'($urandom(80));
        do_reset(1);
        check("pf_oe_rst", pf_oe_o, 8'h00);
        rd(OFF_PE_DIR, 8'hFF);
        rd(OFF_PF_DIR, 8'hFF);
        rd(OFF_PF_PIN, 8'h80);
        rd(OFF_ANA, 8'h7F);
        rd(OFF_STATUS, 8'h01);
        apb(1, 8'h24, 8'hA5, 8'h00, 1);
        apb(0, 8'h24, 8'h00, 8'h00, 1);
        rd(OFF_CTRL, 8'h00);
        wr(OFF_ANA, 8'h00);
        for (i = 0; i < 4; i++) begin
            d = $urandom;
            l = $urandom;
            x = $urandom;
            pe_ext <= x;
            pf_ext <= x;
            wr(OFF_PF_DIR, d);
            wr(OFF_PF_LAT, l);
            wr(OFF_PE_DIR, d);
            wr(OFF_PE_PIN, l);
            sett(3);
            check("pf_oe", pf_oe_o, ~d);
            check("pf_out", pf_out_o & ~d, l & ~d);
            check("pe_oe", pe_oe_o, ~d);
            rd(OFF_PF_LAT, l);
            rd(OFF_PE_LAT, l);
            rd(OFF_PE_PIN, (l & ~d) | (x & d));
            rd(OFF_PF_PIN, (l & ~d) | (x & d));
            rd(OFF_PF_DIR, d);
        end
        wr(OFF_PE_DIR, 8'hFF);
        for (i = 0; i < 4; i++) begin
            c = 8'(i << 2);
            wr(OFF_CTRL, c);
            pwm_out_i <= $urandom;
            pwm_en_i  <= $urandom;
            pc1_in_i  <= $urandom;
            pe_ext    <= $urandom;
            sett(4);
            m = {~c[3], {4{~c[2]}}, 3'b111};
            x = (m & pwm_en_i & pwm_out_i) | (pe_ext & ~(m & pwm_en_i));
            check("pe_pwm_oe", pe_oe_o, pwm_en_i & m);
            check("pe_pwm_out", pe_out_o & pe_oe_o, pwm_out_i & pwm_en_i & m);
            check("ph_pwm", {ph_pwm_oe_o, ph_pwm_out_o & ph_pwm_oe_o},
                  {pwm_en_i[6:3] & {4{c[2]}}, pwm_out_i[6:3] & pwm_en_i[6:3] & {4{c[2]}}});
            check("cap2", {5'h0, pc1_cap2_oe_o, pc1_cap2_out_o & pc1_cap2_oe_o, capture2_in_o},
                  {5'h0, c[3] & pwm_en_i[7], c[3] & pwm_en_i[7] & pwm_out_i[7],
                   c[3] ? pc1_in_i : x[7]});
            check("ttl_port", pe_ttl_sel_o, 8'h00);
        end
        wr(OFF_PE_DIR, 8'h07);
        pwm_en_i <= 8'h00;
        wr(OFF_CTRL, 8'h02);
        rd(OFF_STATUS, 8'h05);
        for (i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            pe_ext <= 8'(i);
            sett(4);
            check("psp", {5'h0, psp_select_o, psp_read_o, psp_write_o},
                  {5'h0, ~pe_ext[2], ~pe_ext[2] & ~pe_ext[0], ~pe_ext[2] & ~pe_ext[1]});
            check("ttl_psp", pe_ttl_sel_o, 8'h07);
        end
        wr(OFF_PE_DIR, 8'h00);
        sett(3);
        check("psp_oe", pe_oe_o, 8'hF8);
        rd(OFF_PE_DIR, 8'h00);
        wr(OFF_PF_DIR, 8'h00);
        wr(OFF_PF_LAT, 8'hFF);
        wr(OFF_CTRL, 8'hF0);
        for (i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            comparator1_result_i <= i[0];
            comparator2_result_i <= i[1];
            pf_ext               <= $urandom;
            sett(3);
            check("pf_cmp_oe", pf_oe_o, 8'h5F);
            check("pf_cmp_out", pf_out_o & 8'h5F,
                  {3'b010, 2'b11, comparator1_result_i, comparator2_result_i, 1'b1});
            check("pf_misc", {5'h0, comparator_ref_voltage_route_o, pf_ss_ttl_o, ss_in_o},
                  {5'h0, 1'b1, 1'b1, pf_ext[7]});
        end
        do_reset(0);
        rd(OFF_STATUS, 8'h02);
        wr(OFF_CTRL, 8'h08);
        pwm_en_i <= 8'hFF;
        for (i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            ebus_ad_out_i <= $urandom;
            ebus_ad_oe_i  <= i[0];
            pe_ext        <= $urandom;
            sett(4);
            check("bus_oe", pe_oe_o, {8{ebus_ad_oe_i}});
            check("bus_out", pe_out_o & pe_oe_o, ebus_ad_out_i & {8{ebus_ad_oe_i}});
            check("bus_in", ebus_ad_in_o, ebus_ad_oe_i ? ebus_ad_out_i : pe_ext);
            check("ttl_bus", pe_ttl_sel_o, 8'hFF);
            check("cap2_off", {7'h0, pc1_cap2_oe_o}, 8'h00);
        end
        wr(OFF_CTRL, 8'h01);
        pwm_en_i <= 8'h7F;
        rd(OFF_STATUS, 8'h00);
        sett(3);
        check("ext_bus_disable_oe", pe_oe_o, 8'h7F);
        rd(OFF_PE_DIR, 8'hFF);
        sett(2);
        end_sim();
    end
endmodule
